/* File: test/udt_timer_test.sv */
// self-checking testbench of the up/down timer with capture
`timescale 1ns/10ps
module udt_timer_test;
    import udt_pkg::*;
    logic           clk;
    logic           reset_n;
    udt_req_t       req;
    logic [NCH-1:0] captureInputA;
    logic [NCH-1:0] captureInputB;
    logic [DW-1:0]  rdata;
    logic [15:0]    q[$];
    logic [15:0]    rv, per, x, cfg;
    logic           up, ins, lvl;
    int             mismatches, n_tests, n, e;

    udt_timer udt_timer_inst (
        .clk           (clk),
        .reset_n       (reset_n),
        .req           (req),
        .captureInputA (captureInputA),
        .captureInputB (captureInputB),
        .rdata         (rdata)
    );

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus tasks and expectations
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    // m back-to-back reads, all kept in q, the last in rv
    task automatic rd(input logic [2:0] a, input int m);
        q.delete();
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        for (int i = 0; i < m; i++) begin
            @(posedge clk);
            if (i == m - 1) req.rd <= 1'b0;
            #1 q.push_back(rdata);
        end
        rv = q[$];
    endtask
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
        n_tests++;
        if (got !== ex) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic drv(input int ch, input logic v);
        if (ins) captureInputB[ch] <= v;
        else captureInputA[ch] <= v;
    endtask
    function automatic logic [15:0] ctrlW(udt_mode_t m, int dv);
        return (16'(m) << CT_MODE_LO) | (16'(dv) << CT_DIV_LO);
    endfunction
    function automatic logic [15:0] chW(logic [1:0] edg, logic [1:0] s, logic sy);
        return {edg, s, sy, 2'b00, 1'b1, 8'h00};
    endfunction
    function automatic logic [15:0] nxt(logic [15:0] v, logic u, logic [15:0] p);
        if (u) return (v >= p) ? v - 16'h0001 : v + 16'h0001;
        return (v == 16'h0000) ? 16'h0001 : v - 16'h0001;
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done();
    end

    // main sequence
    initial begin
        req = '0;
        captureInputA = '0;
        captureInputB = '0;
        reset_n = 1'b0;
        mismatches = 0;
        n_tests = 0;
        void'($urandom(32'hfdc2));
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), 1);
            chk("reset value", 16'h0000, rv);
        end
        // continuous counting, each divider
        for (int d = 0; d < 4; d++) begin
            wr(ADDR_CTRL, ctrlW(MODE_CONT, d));
            rd(ADDR_COUNT, 1);
            x = rv;
            repeat (14) @(posedge clk);
            rd(ADDR_COUNT, 1);
            chk("divided count", x + 16'(16 >> d), rv);
        end
        wr(ADDR_CTRL, ctrlW(MODE_STOP, 0));
        wr(ADDR_COUNT, 16'hfff8);
        wr(ADDR_CTRL, ctrlW(MODE_CONT, 0));
        repeat (20) @(posedge clk);
        rd(ADDR_CTRL, 1);
        chk("wrap flag", ctrlW(MODE_CONT, 0) | 16'h0001, rv & 16'h00f5);
        // up mode, entered above the period
        per = 16'($urandom_range(20, 12));
        wr(ADDR_CTRL, ctrlW(MODE_STOP, 0));
        wr(ADDR_CCTL0, 16'h0000);
        wr(ADDR_CCR0, per);
        wr(ADDR_COUNT, per);
        rd(ADDR_CCTL0, 1);
        chk("flag on write", 16'h0000, rv & 16'h0001);
        wr(ADDR_COUNT, per + 16'h0005);
        wr(ADDR_CTRL, ctrlW(MODE_UP, 0));
        rd(ADDR_COUNT, 1);
        chk("restart", 16'h0000, rv);
        x = rv;
        n = $urandom_range(30, 0);
        repeat (n) @(posedge clk);
        rd(ADDR_COUNT, 1);
        chk("up count", 16'((x + n + 2) % (per + 1)), rv);
        repeat (45) @(posedge clk);
        rd(ADDR_CTRL, 1);
        chk("up wrap", ctrlW(MODE_UP, 0) | 16'h0001, rv & 16'h00f5);
        rd(ADDR_CCTL0, 1);
        chk("period flag", 16'h0001, rv & 16'h0001);
        // period written below the count rolls to zero
        wr(ADDR_CTRL, ctrlW(MODE_STOP, 0));
        wr(ADDR_COUNT, 16'h000a);
        wr(ADDR_CTRL, ctrlW(MODE_UP, 0));
        wr(ADDR_CCR0, 16'h0004);
        rd(ADDR_COUNT, 1);
        chk("short period", 16'h0000, rv);
        // zero period halts, nonzero restarts upward
        wr(ADDR_CCR0, 16'h0000);
        rd(ADDR_COUNT, 3);
        chk("zero period", q[0], q[2]);
        wr(ADDR_CCR0, per);
        rd(ADDR_COUNT, 2);
        chk("restart up", 16'h0001, 16'(q[0] < 4 && q[1] == q[0] + 1));
        // up/down walk
        wr(ADDR_CTRL, ctrlW(MODE_UPDOWN, 0));
        rd(ADDR_COUNT, 2 * per + 6);
        up = q[1] > q[0];
        for (int i = 1; i < q.size() - 1; i++) begin
            chk("up/down step", nxt(q[i], up, per), q[i + 1]);
            up = q[i + 1] > q[i];
        end
        rd(ADDR_CTRL, 1);
        chk("up/down flag", ctrlW(MODE_UPDOWN, 0) | 16'h0001, rv & 16'h00f5);
        // period written while ascending, then while descending
        wr(ADDR_CTRL, ctrlW(MODE_STOP, 0) | 16'h0004);
        wr(ADDR_COUNT, 16'h0008);
        wr(ADDR_CTRL, ctrlW(MODE_UPDOWN, 0));
        wr(ADDR_CCR0, 16'h0004);
        rd(ADDR_COUNT, 2);
        chk("turn on short period", 16'h0008, q[1]);
        wr(ADDR_CCR0, per);
        rd(ADDR_COUNT, 2);
        chk("keep descending", q[0] - 16'h0001, q[1]);
        // direction kept across stop, dropped by clear
        wr(ADDR_CTRL, ctrlW(MODE_STOP, 0) | 16'h0004);
        wr(ADDR_CTRL, ctrlW(MODE_UPDOWN, 0));
        repeat (per + 3) @(posedge clk);
        wr(ADDR_CTRL, ctrlW(MODE_STOP, 0));
        rd(ADDR_COUNT, 3);
        chk("stopped", q[0], q[2]);
        wr(ADDR_CTRL, ctrlW(MODE_UPDOWN, 0));
        rd(ADDR_COUNT, 2);
        chk("latched down", q[0] - 16'h0001, q[1]);
        wr(ADDR_CTRL, ctrlW(MODE_STOP, 0) | 16'h0004);
        rd(ADDR_COUNT, 1);
        chk("cleared", 16'h0000, rv);
        wr(ADDR_CTRL, ctrlW(MODE_UPDOWN, 0));
        rd(ADDR_COUNT, 2);
        chk("cleared dir", q[0] + 16'h0001, q[1]);
        wr(ADDR_CTRL, ctrlW(MODE_STOP, 0));
        // one edge choice per channel, two edges without a read between
        for (int ch = 0; ch < NCH; ch++) begin
            e = ch + 1;
            ins = 1'($urandom_range(1, 0));
            cfg = chW(2'(e), {1'b0, ins}, 1'($urandom_range(1, 0)));
            lvl = (e == 2);
            drv(ch, lvl);
            x = 16'($urandom);
            wr(ADDR_COUNT, x);
            wr(ADDR_CCTL0 + 3'(ch), cfg);
            repeat (6) @(posedge clk);
            drv(ch, !lvl);
            repeat (8) @(posedge clk);
            wr(ADDR_COUNT, x + 16'h0001);
            drv(ch, lvl);
            repeat (8) @(posedge clk);
            rd(ADDR_CCTL0 + 3'(ch), 1);
            chk("status", cfg | 16'(e == 3) << 1 | 16'(lvl) << 3 | 16'h0001,
                rv & 16'hf90b);
            rd(ADDR_CCR0 + 3'(ch), 1);
            chk("captured", x + 16'(e == 3), rv);
            rd(ADDR_CCTL0 + 3'(ch), 1);
            chk("overflow kept", 16'(e == 3) << 1, rv & 16'h0002);
            wr(ADDR_CCTL0 + 3'(ch), cfg);
            rd(ADDR_CCTL0 + 3'(ch), 1);
            chk("flags cleared", 16'h0000, rv & 16'h0003);
        end
        // software capture by switching the constant source
        x = 16'($urandom);
        wr(ADDR_COUNT, x);
        cfg = chW(2'h3, INSEL_GND, 1'b1);
        wr(ADDR_CCTL0, cfg);
        repeat (6) @(posedge clk);
        wr(ADDR_CCTL0, cfg);
        wr(ADDR_CCTL0, cfg | 16'h1000);
        repeat (6) @(posedge clk);
        rd(ADDR_CCTL0, 1);
        chk("soft status", cfg | 16'h1009, rv & 16'hf90b);
        rd(ADDR_CCR0, 1);
        chk("soft capture", x, rv);
        test_done();
    end
endmodule // udt_timer_test

/* File: verilog/udt_pkg.sv */
// package: constants, types and register map of the up/down timer with capture
package udt_pkg;
    localparam int          DW          = 16;
    localparam int          AW          = 3;
    localparam int          NCH         = 3;
    // register indexes
    localparam logic [2:0]  ADDR_CTRL   = 3'h0;
    localparam logic [2:0]  ADDR_COUNT  = 3'h1;
    localparam logic [2:0]  ADDR_CCTL0  = 3'h2;
    localparam logic [2:0]  ADDR_CCR0   = 3'h5;
    // control register fields
    localparam int          CT_ROLL     = 0;
    localparam int          CT_CLEAR    = 2;
    localparam int          CT_MODE_LO  = 4;
    localparam int          CT_DIV_LO   = 6;
    // channel control fields
    localparam int          CC_FLAG     = 0;
    localparam int          CC_OVF      = 1;
    localparam int          CC_LEVEL    = 3;
    localparam int          CC_CAPSEL   = 8;
    localparam int          CC_SYNC     = 11;
    localparam int          CC_INSEL_LO = 12;
    localparam int          CC_EDGE_LO  = 14;
    // values
    localparam logic [15:0] CNT_ZERO    = 16'h0000;
    localparam logic [15:0] CNT_ONE     = 16'h0001;
    localparam logic [15:0] CNT_MAX     = 16'hffff;
    localparam logic [15:0] RD_ZERO     = 16'h0000;
    localparam logic [2:0]  DIV_ZERO    = 3'h0;
    localparam logic [2:0]  DIV_ONE     = 3'h1;

    typedef enum logic [1:0] {
        MODE_STOP,
        MODE_UP,
        MODE_CONT,
        MODE_UPDOWN
    } udt_mode_t;

    // input select codes: a, b, ground, supply
    localparam logic [1:0]  INSEL_A     = 2'h0;
    localparam logic [1:0]  INSEL_B     = 2'h1;
    localparam logic [1:0]  INSEL_GND   = 2'h2;

    typedef struct packed {
        logic           wr;
        logic           rd;
        logic [AW-1:0]  addr;
        logic [DW-1:0]  wdata;
    } udt_req_t;

    typedef struct packed {
        logic       capSel;
        logic [1:0] edgeSel;
        logic [1:0] inSel;
        logic       syncCap;
    } udt_chctl_t;
endpackage

/* File: verilog/udt_timer.sv */
// up/down timer with three capture channels and a plain register port
`timescale 1ns/10ps
module udt_timer
    import udt_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           reset_n,
    input  wire udt_req_t       req,
    input  wire logic [NCH-1:0] captureInputA,
    input  wire logic [NCH-1:0] captureInputB,
    output logic      [DW-1:0]  rdata
);

    ////////////////////////////////////////////////////////////////////////
    // state
    udt_mode_t          countMode;
    logic [1:0]         divSel;
    logic [2:0]         divCnt;
    logic [DW-1:0]      countValue;
    logic               dirDown;
    logic               rolloverFlag;
    udt_chctl_t         chCtl       [NCH];
    logic [DW-1:0]      chReg       [NCH];
    logic [NCH-1:0]     chFlag;
    logic [NCH-1:0]     chOvf;
    logic [NCH-1:0]     chUnread;
    logic [NCH-1:0]     chPend;
    logic [NCH-1:0]     prevLevel;
    logic [NCH-1:0]     syncA1;
    logic [NCH-1:0]     syncA2;
    logic [NCH-1:0]     syncB1;
    logic [NCH-1:0]     syncB2;

    logic               tick;
    logic               clearHit;
    logic               counting;
    logic [DW-1:0]      next_count;
    logic               next_dirDown;
    logic               rollSet;
    logic               periodWrite;
    logic               periodRestart;
    logic [NCH-1:0]     hitSet;
    logic [NCH-1:0]     selLevel;
    logic [NCH-1:0]     capEdge;
    logic [NCH-1:0]     capFire;

    // decode of a register index from the bus
    function automatic logic hitAddr(input udt_req_t r, input logic [AW-1:0] a);
        return r.addr == a;
    endfunction

    // channel control packed into its register image
    function automatic logic [DW-1:0] cctlImage(input udt_chctl_t c, input logic f,
                                                input logic o, input logic lv);
        logic [DW-1:0] v;
        v = RD_ZERO;
        v[CC_FLAG] = f;
        v[CC_OVF] = o;
        v[CC_LEVEL] = lv;
        v[CC_CAPSEL] = c.capSel;
        v[CC_SYNC] = c.syncCap;
        v[CC_INSEL_LO +: 2] = c.inSel;
        v[CC_EDGE_LO +: 2] = c.edgeSel;
        return v;
    endfunction

    assign clearHit    = req.wr && hitAddr(req, ADDR_CTRL) && req.wdata[CT_CLEAR];
    assign periodWrite = req.wr && hitAddr(req, ADDR_CCR0);
    assign periodRestart = periodWrite && (chReg[0] == CNT_ZERO) && (req.wdata != CNT_ZERO)
                           && (countMode == MODE_UP || countMode == MODE_UPDOWN);
    assign counting    = tick && (countMode != MODE_STOP);

    ////////////////////////////////////////////////////////////////////////
    // timer clock divider, one-cycle tick at clk/1, /2, /4, /8
    always_comb begin
        tick = ((divCnt & ((DIV_ONE << divSel) - DIV_ONE)) == DIV_ZERO);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            divCnt <= DIV_ZERO;
        end else if (clearHit) begin
            divCnt <= DIV_ZERO;
        end else begin
            divCnt <= divCnt + DIV_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode and divider control
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            countMode <= MODE_STOP;
            divSel    <= 2'h0;
        end else if (req.wr && hitAddr(req, ADDR_CTRL)) begin
            countMode <= udt_mode_t'(req.wdata[CT_MODE_LO +: 2]);
            divSel    <= req.wdata[CT_DIV_LO +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next count, direction and reach events
    always_comb begin
        next_count   = countValue;
        next_dirDown = dirDown;
        rollSet      = 1'b0;
        case (countMode)
            MODE_UP: begin
                if (chReg[0] == CNT_ZERO) begin
                    next_count = countValue;
                end else if (countValue >= chReg[0]) begin
                    next_count = CNT_ZERO;
                    rollSet    = (countValue == chReg[0]);
                end else begin
                    next_count = countValue + CNT_ONE;
                end
            end
            MODE_CONT: begin
                next_count = countValue + CNT_ONE;
                rollSet    = (countValue == CNT_MAX);
            end
            MODE_UPDOWN: begin
                if (dirDown) begin
                    if (countValue == CNT_ZERO) begin
                        next_dirDown = 1'b0;
                        next_count   = (chReg[0] == CNT_ZERO) ? CNT_ZERO : CNT_ONE;
                    end else begin
                        next_count = countValue - CNT_ONE;
                        rollSet    = (countValue == CNT_ONE);
                    end
                end else if (chReg[0] == CNT_ZERO) begin
                    next_count = countValue;
                end else if (countValue >= chReg[0]) begin
                    next_dirDown = 1'b1;
                    next_count   = countValue - CNT_ONE;
                end else begin
                    next_count = countValue + CNT_ONE;
                end
            end
            default: begin
                next_count = countValue;
            end
        endcase
    end

    // reach event per channel: channel 0 is the period flag in up and up/down
    generate
        for (genvar i = 0; i < NCH; i++) begin : g_hit
            if (i == 0) begin : g_period
                assign hitSet[i] = counting && (next_count != countValue)
                    && (next_count == chReg[i])
                    && ((countMode == MODE_UP || countMode == MODE_UPDOWN)
                        || !chCtl[i].capSel);
            end else begin : g_other
                assign hitSet[i] = counting && (next_count != countValue)
                    && (next_count == chReg[i]) && !chCtl[i].capSel;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // counter and latched direction
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            countValue <= CNT_ZERO;
            dirDown    <= 1'b0;
        end else if (clearHit) begin
            countValue <= CNT_ZERO;
            dirDown    <= 1'b0;
        end else if (req.wr && hitAddr(req, ADDR_COUNT)) begin
            countValue <= req.wdata;
        end else if (periodRestart) begin
            countValue <= CNT_ZERO;
            dirDown    <= 1'b0;
        end else if (counting) begin
            countValue <= next_count;
            dirDown    <= next_dirDown;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rollover flag, hardware set wins over software write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rolloverFlag <= 1'b0;
        end else if (counting && rollSet) begin
            rolloverFlag <= 1'b1;
        end else if (req.wr && hitAddr(req, ADDR_CTRL)) begin
            rolloverFlag <= req.wdata[CT_ROLL];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers, two flops before any use
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            syncA1 <= '0;
            syncA2 <= '0;
            syncB1 <= '0;
            syncB2 <= '0;
        end else begin
            syncA1 <= captureInputA;
            syncA2 <= syncA1;
            syncB1 <= captureInputB;
            syncB2 <= syncB1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture channels
    generate
        for (genvar i = 0; i < NCH; i++) begin : g_ch
            logic lvl;
            logic rise;
            logic fall;
            // source select: a, b, ground, supply
            always_comb begin
                case (chCtl[i].inSel)
                    INSEL_A:   lvl = syncA2[i];
                    INSEL_B:   lvl = syncB2[i];
                    INSEL_GND: lvl = 1'b0;
                    default:   lvl = 1'b1;
                endcase
            end
            assign selLevel[i] = lvl;
            assign rise = lvl && !prevLevel[i];
            assign fall = !lvl && prevLevel[i];
            assign capEdge[i] = chCtl[i].capSel &&
                ((chCtl[i].edgeSel[0] && rise) || (chCtl[i].edgeSel[1] && fall));
            assign capFire[i] = chCtl[i].syncCap ? ((chPend[i] || capEdge[i]) && tick)
                                                 : capEdge[i];

            // edge history and deferred capture
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    prevLevel[i] <= 1'b0;
                    chPend[i]    <= 1'b0;
                end else begin
                    prevLevel[i] <= lvl;
                    chPend[i]    <= chCtl[i].syncCap && (chPend[i] || capEdge[i])
                                    && !tick && chCtl[i].capSel;
                end
            end

            // channel control register
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    chCtl[i] <= '0;
                end else if (req.wr && hitAddr(req, AW'(ADDR_CCTL0 + i))) begin
                    chCtl[i].capSel  <= req.wdata[CC_CAPSEL];
                    chCtl[i].syncCap <= req.wdata[CC_SYNC];
                    chCtl[i].inSel   <= req.wdata[CC_INSEL_LO +: 2];
                    chCtl[i].edgeSel <= req.wdata[CC_EDGE_LO +: 2];
                end
            end

            // capture/compare value, unbuffered
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    chReg[i] <= CNT_ZERO;
                end else if (capFire[i]) begin
                    chReg[i] <= countValue;
                end else if (req.wr && hitAddr(req, AW'(ADDR_CCR0 + i))) begin
                    chReg[i] <= req.wdata;
                end
            end

            // event flag, overflow and unread tracking, set wins
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    chFlag[i]   <= 1'b0;
                    chOvf[i]    <= 1'b0;
                    chUnread[i] <= 1'b0;
                end else begin
                    if (capFire[i] || hitSet[i]) begin
                        chFlag[i] <= 1'b1;
                    end else if (req.wr && hitAddr(req, AW'(ADDR_CCTL0 + i))) begin
                        chFlag[i] <= req.wdata[CC_FLAG];
                    end
                    if (capFire[i] && chUnread[i]) begin
                        chOvf[i] <= 1'b1;
                    end else if (req.wr && hitAddr(req, AW'(ADDR_CCTL0 + i))) begin
                        chOvf[i] <= req.wdata[CC_OVF];
                    end
                    if (capFire[i]) begin
                        chUnread[i] <= 1'b1;
                    end else if (req.rd && hitAddr(req, AW'(ADDR_CCR0 + i))) begin
                        chUnread[i] <= 1'b0;
                    end
                end
            end

            // a capture copies the count and raises the flag
            a_capture_copy: assert property (@(posedge clk) disable iff (!reset_n)
                capFire[i] |=> (chReg[i] == $past(countValue)) && chFlag[i])
                else $error("capture did not copy count");
            // a second capture before reading sets overflow
            a_capture_ovf: assert property (@(posedge clk) disable iff (!reset_n)
                (capFire[i] && chUnread[i]) |=> chOvf[i])
                else $error("capture overflow not flagged");
            // synced capture fires only on a timer tick
            a_sync_tick: assert property (@(posedge clk) disable iff (!reset_n)
                (capFire[i] && chCtl[i].syncCap) |-> tick)
                else $error("synced capture off the tick");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the read strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= RD_ZERO;
        end else if (req.rd) begin
            rdata <= RD_ZERO;
            if (hitAddr(req, ADDR_CTRL)) begin
                rdata[CT_ROLL]         <= rolloverFlag;
                rdata[CT_MODE_LO +: 2] <= countMode;
                rdata[CT_DIV_LO +: 2]  <= divSel;
            end else if (hitAddr(req, ADDR_COUNT)) begin
                rdata <= countValue;
            end
            for (int k = 0; k < NCH; k++) begin
                if (hitAddr(req, AW'(ADDR_CCTL0 + k))) begin
                    rdata <= cctlImage(chCtl[k], chFlag[k], chOvf[k], selLevel[k]);
                end
                if (hitAddr(req, AW'(ADDR_CCR0 + k))) begin
                    rdata <= chReg[k];
                end
            end
        end else begin
            rdata <= RD_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_clear_zero: assert property (@(posedge clk) disable iff (!reset_n)
        clearHit |=> (countValue == CNT_ZERO) && !dirDown && (divCnt == DIV_ZERO))
        else $error("clear left count, direction or divider");
    a_up_wrap: assert property (@(posedge clk) disable iff (!reset_n)
        (counting && countMode == MODE_UP && countValue == chReg[0] && chReg[0] != CNT_ZERO
         && !req.wr) |=> (countValue == CNT_ZERO) && rolloverFlag)
        else $error("up mode did not wrap at period");
    a_cont_wrap: assert property (@(posedge clk) disable iff (!reset_n)
        (counting && countMode == MODE_CONT && countValue == CNT_MAX && !req.wr)
        |=> (countValue == CNT_ZERO) && rolloverFlag)
        else $error("continuous wrap missed rollover");
    a_stop_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (countMode == MODE_STOP && !req.wr) |=> $stable(countValue) && $stable(dirDown))
        else $error("counter moved while stopped");
    a_updown_turn: assert property (@(posedge clk) disable iff (!reset_n)
        (counting && countMode == MODE_UPDOWN && !dirDown && chReg[0] != CNT_ZERO
         && countValue >= chReg[0] && countValue != CNT_ZERO && !req.wr)
        |=> dirDown && (countValue == $past(countValue) - CNT_ONE))
        else $error("up/down did not turn at period");
    a_write_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        (req.wr && hitAddr(req, ADDR_COUNT) && !counting && !capFire[0])
        |=> !$rose(rolloverFlag) && !$rose(chFlag[0]))
        else $error("write to count raised a flag");

    c_capture: cover property (@(posedge clk) disable iff (!reset_n) capFire[0]);
    c_overflow: cover property (@(posedge clk) disable iff (!reset_n) $rose(chOvf[2]));
    c_rollover: cover property (@(posedge clk) disable iff (!reset_n) $rose(rolloverFlag));
    c_turn: cover property (@(posedge clk) disable iff (!reset_n) $rose(dirDown));

endmodule // udt_timer
